// ### shared/usbep0_pkg.sv
package usbep0_pkg;
	// register byte offsets on the ahb-lite slave
	localparam logic [3:0] USBEP0_OFS_CSR = 4'h0;
	localparam logic [3:0] USBEP0_OFS_FIFO = 4'h4;
	localparam logic [3:0] USBEP0_OFS_COUNT = 4'h8;
	localparam logic [3:0] USBEP0_OFS_MODE = 4'hC;
	// ep0_ctrl_status_reg field positions
	localparam int USBEP0_B_RXRDY = 0;
	localparam int USBEP0_B_TXRDY = 1;
	localparam int USBEP0_B_STALL_SENT = 2;
	localparam int USBEP0_B_DATA_END = 3;
	localparam int USBEP0_B_PREM_END = 4;
	localparam int USBEP0_B_STALL_REQ = 5;
	localparam int USBEP0_B_SERVICED = 6;
	localparam int USBEP0_B_PREM_ACK = 7;
	localparam logic [7:0] USBEP0_CSR_RESET = 8'h00;
	// endpoint 0 sizes
	localparam logic [6:0] USBEP0_MAX_PKT = 7'h40;
	localparam logic [6:0] USBEP0_SETUP_LEN = 7'h08;
	localparam int USBEP0_DEPTH = 64;
	localparam logic [6:0] USBEP0_CNT_ZERO = 7'h00;
	localparam logic [31:0] USBEP0_RD_ZERO = 32'h0000_0000;
	// setup byte positions used by the decoder
	localparam logic [6:0] USBEP0_SETUP_TYPE_IDX = 7'h00;
	localparam logic [6:0] USBEP0_SETUP_LEN_LO = 7'h06;
	localparam logic [6:0] USBEP0_SETUP_LEN_HI = 7'h07;

	typedef enum logic [2:0]
	{
		USBEP0_M_IDLE = 3'b000,
		USBEP0_M_TX = 3'b001,
		USBEP0_M_RX = 3'b010,
		USBEP0_M_ST_IN = 3'b011,
		USBEP0_M_ST_OUT = 3'b100
	} usbep0_mode_t;

	typedef enum logic [1:0]
	{
		USBEP0_TOK_SETUP = 2'b00,
		USBEP0_TOK_OUT = 2'b01,
		USBEP0_TOK_IN = 2'b10
	} usbep0_tok_t;

	typedef enum logic [1:0]
	{
		USBEP0_RSP_ACK = 2'b00,
		USBEP0_RSP_NAK = 2'b01,
		USBEP0_RSP_STALL = 2'b10,
		USBEP0_RSP_DATA = 2'b11
	} usbep0_rsp_t;

	typedef enum logic [1:0]
	{
		USBEP0_RK_SETUP = 2'b00,
		USBEP0_RK_DATA = 2'b01,
		USBEP0_RK_STATUS = 2'b10,
		USBEP0_RK_DISCARD = 2'b11
	} usbep0_rk_t;

	// from the usb protocol engine
	typedef struct packed
	{
		logic tok_valid;
		usbep0_tok_t tok_kind;
		logic rx_valid;
		logic [7:0] rx_data;
		logic rx_done;
		logic rx_ok;
		logic tx_pop;
		logic tx_ack;
	} usbep0_link_in_t;

	// to the usb protocol engine
	typedef struct packed
	{
		logic rsp_valid;
		usbep0_rsp_t rsp_kind;
		logic [6:0] tx_len;
		logic [7:0] tx_data;
	} usbep0_link_out_t;
endpackage

// ### verilog/usbep0_fifo.sv
`timescale 1ns/1ps
module usbep0_fifo
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic flush,
	input wire logic push,
	input wire logic [7:0] din,
	input wire logic pop,
	output logic [7:0] dout,
	output logic [6:0] count
);
	import usbep0_pkg::*;

	typedef struct packed
	{
		logic [USBEP0_DEPTH-1:0][7:0] mem;
		logic [5:0] wptr;
		logic [5:0] rptr;
		logic [6:0] cnt;
	} usbep0_fifo_st_t;

	usbep0_fifo_st_t st_ff;
	usbep0_fifo_st_t nxt_st;
	logic do_push;
	logic do_pop;

	// a full push and an empty pop are dropped so the pointers never wrap past each other
	assign do_push = push && (st_ff.cnt != USBEP0_MAX_PKT);
	assign do_pop = pop && (st_ff.cnt != USBEP0_CNT_ZERO);
	assign dout = st_ff.mem[st_ff.rptr];
	assign count = st_ff.cnt;

	always_comb
	begin
		nxt_st = st_ff;
		if (flush)
		begin
			nxt_st.wptr = 6'h00;
			nxt_st.rptr = 6'h00;
			nxt_st.cnt = USBEP0_CNT_ZERO;
		end
		else
		begin
			if (do_push)
			begin
				nxt_st.mem[st_ff.wptr] = din;
				nxt_st.wptr = st_ff.wptr + 6'h01;
			end
			if (do_pop)
				nxt_st.rptr = st_ff.rptr + 6'h01;
			if (do_push && !do_pop)
				nxt_st.cnt = st_ff.cnt + 7'h01;
			else if (do_pop && !do_push)
				nxt_st.cnt = st_ff.cnt - 7'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule // usbep0_fifo

// ### verilog/usbep0_ctrl.sv
// Operation
// (R01) software sets serviced bit 6 after unloading the 8-byte setup command
// (R02) software loads at most one max packet per turn, then sets transmit-ready bit 1
// (R03) final reply packet: software sets transmit-ready and data-end bit 3 together
// (R04) status stage completion raises the endpoint 0 interrupt
// (R05) serviced plus stall-request bit 5: next data token stalled, stall-sent set, interrupt
// (R06) token after data-end beyond expected data gets stall, stall-sent bit 2, interrupt
// (R07) endpoint 0 modes idle, tx, rx; reset enters idle
// (R08) receive-ready set in idle marks a new device request
// (R09) device decodes setup for data phase and direction, switches fifo itself
// (R10) no data phase stays idle, out phase goes rx, in phase goes tx
// (R11) valid packet stored in fifo sets receive-ready bit 0 and interrupts
// (R12) acknowledged transmit clears transmit-ready bit 1 and interrupts
// (R13) protocol violation ends transaction with stall-sent bit 2 and interrupt
// (R14) transfer ended before data-end sets premature-end bit 4 and interrupts
// (R15) service routine checks stall-sent and premature-end first, aborting to idle
// (R16) in idle software accepts only received data, then unloads the setup packet
// (R17) in tx each interrupt is a served in token; load more or set data-end
// (R18) in rx software unloads each packet; data-end when done, else serviced
// (R19) setup packets whose command is not exactly 8 bytes are rejected
// (R20) premature-end acknowledge bit 7 clears the premature-end flag
// (R21) each status flag stays set until software clears it; hardware also clears receive-ready, transmit-ready and data-end
`timescale 1ns/1ps
module usbep0_ctrl
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire usbep0_pkg::usbep0_link_in_t link_in,
	output usbep0_pkg::usbep0_link_out_t link_out,
	output logic ep0_irq
);
	import usbep0_pkg::*;

	typedef struct packed
	{
		usbep0_mode_t mode;
		logic [7:0] csr;
		logic setup_pending;
		logic setup_dir_in;
		logic setup_has_data;
		logic fifo_dir_in;
		logic rx_sink;
		usbep0_rk_t rx_kind;
		logic [6:0] rx_cnt;
		logic rx_over;
		logic sending;
		logic send_status;
		logic dp_wr;
		logic [3:0] dp_addr;
		logic [31:0] rdata;
		logic irq;
		logic rsp_valid;
		usbep0_rsp_t rsp_kind;
		logic [6:0] tx_len;
	} usbep0_st_t;

	usbep0_st_t st_ff;
	usbep0_st_t nxt_st;
	logic ap_valid;
	logic fifo_flush;
	logic fifo_push;
	logic [7:0] fifo_din;
	logic fifo_pop;
	logic [7:0] fifo_dout;
	logic [6:0] fifo_count;
	logic [7:0] wbits;
	usbep0_mode_t rd_mode;

	assign ap_valid = hsel && hready && htrans[1];
	assign wbits = hwdata[7:0];
	// (R10) status stages read as idle
	// software only tracks idle, tx and rx, so the inner status steps stay hidden
	assign rd_mode = (st_ff.mode == USBEP0_M_TX || st_ff.mode == USBEP0_M_RX) ? st_ff.mode : USBEP0_M_IDLE;
	// zero wait state: read data is sampled at the address phase, writes land in the data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;
	assign ep0_irq = st_ff.irq;
	assign link_out.rsp_valid = st_ff.rsp_valid;
	assign link_out.rsp_kind = st_ff.rsp_kind;
	assign link_out.tx_len = st_ff.tx_len;
	assign link_out.tx_data = fifo_dout;

	usbep0_fifo u_fifo
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.flush(fifo_flush),
		.push(fifo_push),
		.din(fifo_din),
		.pop(fifo_pop),
		.dout(fifo_dout),
		.count(fifo_count)
	);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.irq = 1'b0;
		nxt_st.rsp_valid = 1'b0;
		fifo_flush = 1'b0;
		fifo_push = 1'b0;
		fifo_din = link_in.rx_data;
		fifo_pop = 1'b0;

		// register bus: address phase
		if (ap_valid)
		begin
			nxt_st.dp_wr = hwrite;
			nxt_st.dp_addr = haddr[3:0];
			nxt_st.rdata = USBEP0_RD_ZERO;
			if (!hwrite)
			begin
				case (haddr[3:0])
					USBEP0_OFS_CSR: nxt_st.rdata = {24'h00_0000, st_ff.csr};
					USBEP0_OFS_FIFO:
					begin
						nxt_st.rdata = {24'h00_0000, fifo_dout};
						fifo_pop = !st_ff.fifo_dir_in;
					end
					USBEP0_OFS_COUNT: nxt_st.rdata = {25'h000_0000, fifo_count};
					USBEP0_OFS_MODE: nxt_st.rdata = {28'h000_0000, st_ff.fifo_dir_in, rd_mode};
					default: nxt_st.rdata = USBEP0_RD_ZERO;
				endcase
			end
		end
		else
			nxt_st.dp_wr = 1'b0;

		// register bus: write data phase; software clears come before hardware sets below
		if (st_ff.dp_wr && st_ff.dp_addr == USBEP0_OFS_FIFO && st_ff.fifo_dir_in)
		begin
			fifo_din = wbits;
			fifo_push = 1'b1;
		end
		if (st_ff.dp_wr && st_ff.dp_addr == USBEP0_OFS_CSR)
		begin
			// (R21) stall-sent clear
			if (wbits[USBEP0_B_STALL_SENT])
				nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b0;
			// (R20) premature-end acknowledge
			if (wbits[USBEP0_B_PREM_ACK])
				nxt_st.csr[USBEP0_B_PREM_END] = 1'b0;
			// (R05) stall request latch
			nxt_st.csr[USBEP0_B_STALL_REQ] = wbits[USBEP0_B_STALL_REQ];
			// (R02) transmit-ready set
			if (wbits[USBEP0_B_TXRDY])
				nxt_st.csr[USBEP0_B_TXRDY] = 1'b1;
			// (R03) data-end set
			if (wbits[USBEP0_B_DATA_END])
				nxt_st.csr[USBEP0_B_DATA_END] = 1'b1;
			// (R01) serviced clears receive-ready
			if (wbits[USBEP0_B_SERVICED])
			begin
				nxt_st.csr[USBEP0_B_RXRDY] = 1'b0;
				fifo_flush = 1'b1;
				// (R10) pick the data phase mode
				if (st_ff.mode == USBEP0_M_IDLE && st_ff.setup_pending)
				begin
					nxt_st.setup_pending = 1'b0;
					if (wbits[USBEP0_B_STALL_REQ])
						nxt_st.mode = st_ff.setup_dir_in ? USBEP0_M_TX : USBEP0_M_RX;
					else if (!st_ff.setup_has_data || wbits[USBEP0_B_DATA_END])
						nxt_st.mode = USBEP0_M_ST_IN;
					else if (st_ff.setup_dir_in)
						nxt_st.mode = USBEP0_M_TX;
					else
						nxt_st.mode = USBEP0_M_RX;
					// (R09) fifo direction follows the decoded request
					nxt_st.fifo_dir_in = st_ff.setup_dir_in && st_ff.setup_has_data;
				end
				// (R18) last packet unloaded in rx
				else if (st_ff.mode == USBEP0_M_RX && wbits[USBEP0_B_DATA_END])
					nxt_st.mode = USBEP0_M_ST_IN;
			end
		end

		// link: tokens
		if (link_in.tok_valid)
		begin
			nxt_st.rsp_valid = 1'b1;
			nxt_st.rsp_kind = USBEP0_RSP_NAK;
			nxt_st.tx_len = USBEP0_CNT_ZERO;
			if (link_in.tok_kind == USBEP0_TOK_SETUP)
			begin
				// (R14) new setup before data-end
				if ((st_ff.mode == USBEP0_M_TX || st_ff.mode == USBEP0_M_RX) && !st_ff.csr[USBEP0_B_DATA_END])
				begin
					nxt_st.csr[USBEP0_B_PREM_END] = 1'b1;
					nxt_st.irq = 1'b1;
				end
				// setup is always taken; its answer waits for the end of the packet
				nxt_st.rsp_valid = 1'b0;
				nxt_st.mode = USBEP0_M_IDLE;
				nxt_st.csr[USBEP0_B_TXRDY] = 1'b0;
				nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
				nxt_st.csr[USBEP0_B_RXRDY] = 1'b0;
				nxt_st.setup_pending = 1'b0;
				nxt_st.setup_has_data = 1'b0;
				nxt_st.fifo_dir_in = 1'b0;
				nxt_st.sending = 1'b0;
				nxt_st.rx_sink = 1'b1;
				nxt_st.rx_kind = USBEP0_RK_SETUP;
				nxt_st.rx_cnt = USBEP0_CNT_ZERO;
				nxt_st.rx_over = 1'b0;
				fifo_flush = 1'b1;
			end
			else if (st_ff.csr[USBEP0_B_STALL_REQ] && st_ff.mode != USBEP0_M_IDLE)
			begin
				// (R05) software asked to stall this request
				nxt_st.rsp_kind = USBEP0_RSP_STALL;
				nxt_st.csr[USBEP0_B_STALL_REQ] = 1'b0;
				nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b1;
				nxt_st.csr[USBEP0_B_TXRDY] = 1'b0;
				nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
				nxt_st.mode = USBEP0_M_IDLE;
				nxt_st.irq = 1'b1;
			end
			else if (link_in.tok_kind == USBEP0_TOK_IN)
			begin
				case (st_ff.mode)
					USBEP0_M_TX:
					begin
						if (st_ff.csr[USBEP0_B_TXRDY])
						begin
							nxt_st.rsp_kind = USBEP0_RSP_DATA;
							nxt_st.tx_len = fifo_count;
							nxt_st.sending = 1'b1;
							nxt_st.send_status = 1'b0;
						end
					end
					USBEP0_M_ST_IN:
					begin
						nxt_st.rsp_kind = USBEP0_RSP_DATA;
						nxt_st.sending = 1'b1;
						nxt_st.send_status = 1'b1;
					end
					USBEP0_M_ST_OUT:
					begin
						// (R06) in token after the last packet
						nxt_st.rsp_kind = USBEP0_RSP_STALL;
						nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b1;
						nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
						nxt_st.mode = USBEP0_M_IDLE;
						nxt_st.irq = 1'b1;
					end
					USBEP0_M_RX:
					begin
						// (R14) host went to status early
						nxt_st.csr[USBEP0_B_PREM_END] = 1'b1;
						nxt_st.mode = USBEP0_M_IDLE;
						nxt_st.irq = 1'b1;
					end
					default: nxt_st.rsp_kind = USBEP0_RSP_NAK;
				endcase
			end
			else
			begin
				case (st_ff.mode)
					USBEP0_M_RX:
					begin
						if (st_ff.csr[USBEP0_B_RXRDY])
							nxt_st.rsp_kind = USBEP0_RSP_NAK;
						else
						begin
							nxt_st.rsp_valid = 1'b0;
							nxt_st.rx_sink = 1'b1;
							nxt_st.rx_kind = USBEP0_RK_DATA;
						end
					end
					USBEP0_M_ST_OUT:
					begin
						nxt_st.rsp_valid = 1'b0;
						nxt_st.rx_sink = 1'b1;
						nxt_st.rx_kind = USBEP0_RK_STATUS;
					end
					USBEP0_M_ST_IN:
					begin
						// (R06) out token after data-end
						nxt_st.rsp_kind = USBEP0_RSP_STALL;
						nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b1;
						nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
						nxt_st.mode = USBEP0_M_IDLE;
						nxt_st.irq = 1'b1;
					end
					USBEP0_M_TX:
					begin
						// (R14) early status; loaded in data is flushed
						nxt_st.csr[USBEP0_B_PREM_END] = 1'b1;
						nxt_st.csr[USBEP0_B_TXRDY] = 1'b0;
						nxt_st.mode = USBEP0_M_IDLE;
						nxt_st.fifo_dir_in = 1'b0;
						nxt_st.sending = 1'b0;
						nxt_st.irq = 1'b1;
						nxt_st.rsp_valid = 1'b0;
						nxt_st.rx_sink = 1'b1;
						nxt_st.rx_kind = USBEP0_RK_DISCARD;
						fifo_flush = 1'b1;
					end
					default: nxt_st.rsp_kind = USBEP0_RSP_NAK;
				endcase
			end
			nxt_st.rx_cnt = USBEP0_CNT_ZERO;
			nxt_st.rx_over = 1'b0;
		end

		// link: received bytes
		if (st_ff.rx_sink && link_in.rx_valid)
		begin
			if (st_ff.rx_cnt == USBEP0_MAX_PKT)
				nxt_st.rx_over = 1'b1;
			else
				nxt_st.rx_cnt = st_ff.rx_cnt + 7'h01;
			if (st_ff.rx_kind == USBEP0_RK_SETUP || st_ff.rx_kind == USBEP0_RK_DATA)
			begin
				fifo_din = link_in.rx_data;
				fifo_push = 1'b1;
			end
			// (R09) decode direction and length while the setup streams in
			if (st_ff.rx_kind == USBEP0_RK_SETUP)
			begin
				if (st_ff.rx_cnt == USBEP0_SETUP_TYPE_IDX)
					nxt_st.setup_dir_in = link_in.rx_data[7];
				if ((st_ff.rx_cnt == USBEP0_SETUP_LEN_LO || st_ff.rx_cnt == USBEP0_SETUP_LEN_HI)
					&& link_in.rx_data != 8'h00)
					nxt_st.setup_has_data = 1'b1;
			end
		end

		// link: end of a received packet
		if (st_ff.rx_sink && link_in.rx_done)
		begin
			nxt_st.rx_sink = 1'b0;
			nxt_st.rsp_valid = link_in.rx_ok;
			nxt_st.rsp_kind = USBEP0_RSP_ACK;
			if (!link_in.rx_ok)
			begin
				if (st_ff.rx_kind != USBEP0_RK_STATUS)
					fifo_flush = 1'b1;
			end
			else
			begin
				case (st_ff.rx_kind)
					USBEP0_RK_SETUP:
					begin
						// (R19) wrong length setup is dropped unanswered
						if (st_ff.rx_cnt != USBEP0_SETUP_LEN || st_ff.rx_over)
						begin
							nxt_st.rsp_valid = 1'b0;
							fifo_flush = 1'b1;
						end
						else
						begin
							// (R08) new request in idle
							nxt_st.setup_pending = 1'b1;
							// (R11) setup stored
							nxt_st.csr[USBEP0_B_RXRDY] = 1'b1;
							nxt_st.irq = 1'b1;
						end
					end
					USBEP0_RK_DATA:
					begin
						if (st_ff.rx_over)
						begin
							// (R13) oversized out packet
							nxt_st.rsp_kind = USBEP0_RSP_STALL;
							nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b1;
							nxt_st.mode = USBEP0_M_IDLE;
							fifo_flush = 1'b1;
						end
						else
							// (R11) data packet stored
							nxt_st.csr[USBEP0_B_RXRDY] = 1'b1;
						nxt_st.irq = 1'b1;
					end
					USBEP0_RK_STATUS:
					begin
						if (st_ff.rx_cnt != USBEP0_CNT_ZERO || st_ff.rx_over)
						begin
							// (R13) non-empty status packet
							nxt_st.rsp_kind = USBEP0_RSP_STALL;
							nxt_st.csr[USBEP0_B_STALL_SENT] = 1'b1;
						end
						// (R04) read request completed
						nxt_st.mode = USBEP0_M_IDLE;
						nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
						nxt_st.fifo_dir_in = 1'b0;
						nxt_st.irq = 1'b1;
					end
					default: nxt_st.rsp_kind = USBEP0_RSP_ACK;
				endcase
			end
		end

		// link: transmit side
		if (st_ff.sending && link_in.tx_pop && !st_ff.send_status)
			fifo_pop = 1'b1;
		if (st_ff.sending && link_in.tx_ack)
		begin
			nxt_st.sending = 1'b0;
			nxt_st.irq = 1'b1;
			if (st_ff.send_status)
			begin
				// (R04) status stage done
				nxt_st.mode = USBEP0_M_IDLE;
				nxt_st.csr[USBEP0_B_DATA_END] = 1'b0;
			end
			else
			begin
				// (R12) packet taken by the host
				nxt_st.csr[USBEP0_B_TXRDY] = 1'b0;
				if (st_ff.csr[USBEP0_B_DATA_END])
				begin
					nxt_st.mode = USBEP0_M_ST_OUT;
					nxt_st.fifo_dir_in = 1'b0;
				end
			end
		end
		// serviced and prem-ack are strobes and never read back
		nxt_st.csr[USBEP0_B_SERVICED] = 1'b0;
		nxt_st.csr[USBEP0_B_PREM_ACK] = 1'b0;
	end

	// (R07) reset lands in idle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff <= '0;
			st_ff.mode <= USBEP0_M_IDLE;
			st_ff.csr <= USBEP0_CSR_RESET;
		end
		else
			st_ff <= nxt_st;
	end
endmodule // usbep0_ctrl

// ### sim/usbep0_ctrl_asserts.sv
`timescale 1ns/1ps
module usbep0_ctrl_asserts
import usbep0_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire usbep0_pkg::usbep0_link_in_t link_in,
	input wire usbep0_pkg::usbep0_link_out_t link_out,
	input wire logic ep0_irq
);
	logic [3:0] cnt_ff;
	usbep0_tok_t kind_ff;
	// byte count saturates: only the exact setup length matters here
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_ff <= 4'h0;
			kind_ff <= USBEP0_TOK_IN;
		end
		else if (link_in.tok_valid)
		begin
			cnt_ff <= 4'h0;
			kind_ff <= link_in.tok_kind;
		end
		else if (link_in.rx_valid && cnt_ff != 4'hF)
			cnt_ff <= cnt_ff + 4'h1;
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_SETUP_ACK: assert property (
		link_in.rx_done && link_in.rx_ok && kind_ff == USBEP0_TOK_SETUP && cnt_ff == 4'h8
		|-> ##[1:2] (link_out.rsp_valid && link_out.rsp_kind == USBEP0_RSP_ACK && ep0_irq))
		else $error("setup not acknowledged");
	AST_BAD_SETUP: assert property (
		link_in.rx_done && kind_ff == USBEP0_TOK_SETUP && cnt_ff != 4'h8
		|=> (!link_out.rsp_valid && !ep0_irq) [*2])
		else $error("short setup answered");
	AST_IN_ANSWER: assert property (
		link_in.tok_valid && link_in.tok_kind == USBEP0_TOK_IN
		|-> ##[1:2] (link_out.rsp_valid && link_out.rsp_kind != USBEP0_RSP_ACK))
		else $error("in token not answered");
	AST_DATA_ORIGIN: assert property (
		link_out.rsp_valid && link_out.rsp_kind == USBEP0_RSP_DATA
		|-> ($past(link_in.tok_valid) || $past(link_in.tok_valid, 2)) && link_out.tx_len <= USBEP0_MAX_PKT)
		else $error("data packet without in token");
	AST_STALL_IRQ: assert property (
		link_out.rsp_valid && link_out.rsp_kind == USBEP0_RSP_STALL |-> ##[0:1] ep0_irq)
		else $error("stall without interrupt");
	AST_ACK_IRQ: assert property (
		link_in.tx_ack |-> ##[1:2] ep0_irq)
		else $error("sent packet without interrupt");
	AST_RSP_CAUSE: assert property (
		link_out.rsp_valid |-> $past(link_in.tok_valid) || $past(link_in.rx_done)
		|| $past(link_in.tok_valid, 2) || $past(link_in.rx_done, 2))
		else $error("response without cause");
	AST_OUT_ANSWER: assert property (
		link_in.rx_done && link_in.rx_ok && kind_ff == USBEP0_TOK_OUT
		|-> ##[1:2] (link_out.rsp_valid && link_out.rsp_kind != USBEP0_RSP_DATA))
		else $error("out packet not answered");
endmodule // usbep0_ctrl_asserts

bind usbep0_ctrl usbep0_ctrl_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready, .hreadyout, .hresp, .hrdata, .link_in, .link_out, .ep0_irq);

// ### sim/usbep0_host.sv
`timescale 1ns/1ps
module usbep0_host
import usbep0_pkg::*;
(
	input wire logic hclk,
	input wire usbep0_pkg::usbep0_link_out_t link_out,
	output usbep0_pkg::usbep0_link_in_t link_in
);
	logic [1:0] rsp;
	logic [6:0] len;
	logic [7:0] got[$];
	int nrsp;
	int slow;
	initial
	begin
		link_in = '0;
		nrsp = 0;
		slow = 0;
	end
	always @(posedge hclk)
	begin
		if (link_out.rsp_valid === 1'b1)
		begin
			rsp = link_out.rsp_kind;
			len = link_out.tx_len;
			nrsp++;
		end
	end
	// idle data line flips so a stale byte is never mistaken for data
	task automatic put(input logic [5:0] f, input usbep0_tok_t k, input logic [7:0] d);
		@(posedge hclk);
		link_in <= {f[5], k, f[4], f[4] ? d : ~link_in.rx_data, f[3:0]};
	endtask
	task automatic send(input usbep0_tok_t k, input logic [7:0] b[$]);
		rsp = 2'bxx;
		put(6'b100000, k, 8'h00);
		foreach (b[i])
			put(6'b010000, k, b[i]);
		put(6'b001100, k, 8'h00);
		repeat (4) put(6'b000000, k, 8'h00);
	endtask
	task automatic take();
		rsp = 2'bxx;
		got.delete();
		put(6'b100000, USBEP0_TOK_IN, 8'h00);
		repeat (4) put(6'b000000, USBEP0_TOK_IN, 8'h00);
		if (rsp === USBEP0_RSP_DATA)
		begin
			repeat (len)
			begin
				repeat (slow) put(6'b000000, USBEP0_TOK_IN, 8'h00);
				put(6'b000010, USBEP0_TOK_IN, 8'h00);
				@(negedge hclk);
				got.push_back(link_out.tx_data);
			end
			put(6'b000001, USBEP0_TOK_IN, 8'h00);
			repeat (4) put(6'b000000, USBEP0_TOK_IN, 8'h00);
		end
	endtask
endmodule // usbep0_host

// ### sim/usb_ep0_control_transfer_tb_top.sv
`timescale 1ns/1ps
module usb_ep0_control_transfer_tb_top;
	import usbep0_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ep0_irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, x;
	usbep0_link_in_t link_in;
	usbep0_link_out_t link_out;
	int fail_count, checked, irq_n, cyc, i0;
	logic [7:0] q[$], e[$];
	usbep0_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .link_in, .link_out, .ep0_irq);
	usbep0_host host (.hclk, .link_out, .link_in);
	always #5 hclk = ~hclk;
	always @(posedge hclk)
	begin
		irq_n += (ep0_irq === 1'b1);
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] w);
		checked++;
		if (g !== w)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, w);
		end
	endtask
	// hold each phase until hready is sampled high
	task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {28'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		x = hrdata;
	endtask
	task automatic chk(input logic [3:0] a, input logic [31:0] w);
		ahb(1'b0, a, 32'h0000_0000);
		cmp(x, w);
	endtask
	task automatic setup(input logic [7:0] t, input logic [7:0] n, input logic [7:0] w);
		q = {t, 8'($urandom), 8'($urandom), 8'h00, 8'h00, 8'h00, n, 8'h00};
		host.send(USBEP0_TOK_SETUP, q);
		cmp(host.rsp, USBEP0_RSP_ACK);
		chk(USBEP0_OFS_CSR, 32'h0000_0001);
		foreach (q[i])
			chk(USBEP0_OFS_FIFO, {24'h00_0000, q[i]});
		ahb(1'b1, USBEP0_OFS_CSR, {24'h00_0000, w});
	endtask
	task automatic load(input int n);
		e.delete();
		repeat (n)
		begin
			e.push_back(8'($urandom));
			ahb(1'b1, USBEP0_OFS_FIFO, {24'h00_0000, e[$]});
		end
		chk(USBEP0_OFS_COUNT, n);
		// last packet loaded: transmit-ready with data-end
		ahb(1'b1, USBEP0_OFS_CSR, 32'h0000_000A);
		chk(USBEP0_OFS_CSR, 32'h0000_000A);
	endtask
	task automatic in_data(input int n);
		i0 = irq_n;
		host.take();
		cmp(host.rsp, USBEP0_RSP_DATA);
		cmp(host.len, n);
		foreach (e[i])
			cmp(host.got[i], e[i]);
		cmp(irq_n - i0, 1);
		chk(USBEP0_OFS_CSR, 32'h0000_0008);
	endtask
	initial
	begin
		int n;
		void'($urandom(63));
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(USBEP0_OFS_CSR, 32'h0000_0000);
		chk(USBEP0_OFS_MODE, 32'h0000_0000);
		q = {8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h12};
		host.send(USBEP0_TOK_SETUP, q);
		cmp(host.nrsp, 32'h0000_0000);
		cmp(irq_n, 32'h0000_0000);
		chk(USBEP0_OFS_CSR, 32'h0000_0000);
		setup(8'h00, 8'h00, 8'h40);
		chk(USBEP0_OFS_MODE, 32'h0000_0000);
		setup(8'h00, 8'h10, 8'h40);
		chk(USBEP0_OFS_MODE, 32'h0000_0002);
		// one out data packet; software unloads it and stays in rx
		q = {8'($urandom), 8'($urandom), 8'($urandom)};
		i0 = irq_n;
		host.send(USBEP0_TOK_OUT, q);
		cmp(host.rsp, USBEP0_RSP_ACK);
		cmp(irq_n - i0, 1);
		chk(USBEP0_OFS_CSR, 32'h0000_0001);
		chk(USBEP0_OFS_COUNT, 3);
		foreach (q[i])
			chk(USBEP0_OFS_FIFO, {24'h00_0000, q[i]});
		ahb(1'b1, USBEP0_OFS_CSR, 32'h0000_0040);
		chk(USBEP0_OFS_MODE, 32'h0000_0002);
		// in token during an out data phase ends the transfer early
		i0 = irq_n;
		host.take();
		chk(USBEP0_OFS_CSR, 32'h0000_0010);
		cmp(irq_n - i0, 1);
		chk(USBEP0_OFS_CSR, 32'h0000_0010);
		// premature end seen first: acknowledge and abort
		ahb(1'b1, USBEP0_OFS_CSR, 32'h0000_0080);
		chk(USBEP0_OFS_CSR, 32'h0000_0000);
		n = 1 + $urandom % 63;
		setup(8'h80, 8'(n), 8'h40);
		chk(USBEP0_OFS_MODE, 32'h0000_0009);
		load(n);
		in_data(n);
		i0 = irq_n;
		q.delete();
		host.send(USBEP0_TOK_OUT, q);
		cmp(host.rsp, USBEP0_RSP_ACK);
		cmp(irq_n - i0, 1);
		chk(USBEP0_OFS_CSR, 32'h0000_0000);
		chk(USBEP0_OFS_MODE, 32'h0000_0000);
		host.slow = 2;
		setup(8'h80, 8'h40, 8'h40);
		load(64);
		in_data(64);
		host.slow = 0;
		host.take();
		cmp(host.rsp, USBEP0_RSP_STALL);
		chk(USBEP0_OFS_CSR, 32'h0000_0004);
		chk(USBEP0_OFS_CSR, 32'h0000_0004);
		ahb(1'b1, USBEP0_OFS_CSR, 32'h0000_0004);
		chk(USBEP0_OFS_CSR, 32'h0000_0000);
		setup(8'h80, 8'h04, 8'h60);
		i0 = irq_n;
		host.take();
		cmp(host.rsp, USBEP0_RSP_STALL);
		chk(USBEP0_OFS_CSR, 32'h0000_0004);
		cmp(irq_n - i0, 1);
		close_out();
	end
endmodule // usb_ep0_control_transfer_tb_top
